// ===== autoneg_partner_nextpage_regs.sv
// Negotiation result and next-page register bank, AXI4-Lite slave.
// Assumes the arbitration logic drives neg_in synchronous to aclk,
// with page_rx and np_page_sent as one-cycle pulses.
//
// Function
// - Partner ability register captures received ability word; zero after reset.
// - With next pages supported, later pages replace ability after base completion.
// - Ability bit 15 shows partner next-page request.
// - Ability bit 14 follows partner acknowledge from negotiation logic.
// - Ability bit 13 shows partner remote fault.
// - Ability bits 12 to 10 read zero; software writes zero.
// - Ability bits 9 to 5 show partner technology abilities.
// - Ability bits 4 to 0 hold partner selector as received.
// - Expansion resets to 0004h; bits 15 to 5 read zero, ignore writes.
// - Expansion bit 4 shows parallel detection fault.
// - Expansion bit 3 shows partner can exchange extra pages.
// - Expansion bit 2 reads one: local side sends next pages.
// - Expansion bit 1 set on page received, cleared by expansion read.
// - Expansion bit 0 shows partner supports negotiation.
// - Next-page transmit register at 009Ch resets 2001h, forms sent page.
// - Next-page bit 15 set by software when another page follows.
// - Next-page bit 13 selects message page or unformatted page.
// - Next-page bit 12 tells whether local side will comply.
// - Next-page bit 11 read-only, inverse of previous toggle value.
// - Next-page bits 10 to 0 carry code field; default null page.
// - Status bit 8 copies page-received flag; reading it does not clear.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
module autoneg_partner_nextpage_regs
    import an_regs_pkg::*;
#(
    parameter logic LOCAL_NP_CAPABLE = EXPANSION_RESET[EXP_LOCAL_NP]
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire axil_req_t   req,
    output      axil_rsp_t   rsp,
    input  wire neg_in_t     neg_in,
    output      logic [15:0] next_page_word,
    output      logic        page_received_copy
);

    // ********************************************************
    // Decoding helpers
    // ********************************************************
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] o);
        return a[7:2] == o[7:2];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return addr_hit(a, OFS_PARTNER) || addr_hit(a, OFS_EXPANSION) ||
               addr_hit(a, OFS_NP_TX) || addr_hit(a, OFS_XCVR_STATUS);
    endfunction

    function automatic logic [15:0] exp_word(input bank_state_t s);
        return {11'h000, s.pd_fault, s.lp_multi_page, LOCAL_NP_CAPABLE,
                s.page_rcvd, s.lp_neg_capable};
    endfunction

    function automatic logic [15:0] np_word(input bank_state_t s);
        return {s.next_page_request, 1'b0, s.message_page_select,
                s.will_comply_flag, s.alternating_sync_bit, s.np_code};
    endfunction

    function automatic logic [15:0] sts_word(input bank_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[STS_PAGE_COPY] = s.page_rcvd;
        return w;
    endfunction

    function automatic logic [15:0] read_word(input logic [7:0] a,
                                              input bank_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        if (addr_hit(a, OFS_PARTNER)) begin
            w = s.ability;
        end else if (addr_hit(a, OFS_EXPANSION)) begin
            w = exp_word(s);
        end else if (addr_hit(a, OFS_NP_TX)) begin
            w = np_word(s);
        end else if (addr_hit(a, OFS_XCVR_STATUS)) begin
            w = sts_word(s);
        end
        return w;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic [1:0]  strb);
        logic [15:0] w;
        w = old;
        for (int i = 0; i < 2; i++) begin
            if (strb[i]) begin
                w[8*i +: 8] = data[8*i +: 8];
            end
        end
        return w;
    endfunction

    function automatic bank_state_t reset_state();
        bank_state_t s;
        s = '0;
        s.bresp = RESP_OKAY;
        s.rresp = RESP_OKAY;
        s.ability = PARTNER_RESET;
        s.pd_fault = EXPANSION_RESET[4];
        s.lp_multi_page = EXPANSION_RESET[3];
        s.page_rcvd = EXPANSION_RESET[1];
        s.lp_neg_capable = EXPANSION_RESET[0];
        s.next_page_request = NP_TX_RESET[NP_SEND];
        s.message_page_select = NP_TX_RESET[NP_MSG_PAGE];
        s.will_comply_flag = NP_TX_RESET[NP_COMPLY];
        s.alternating_sync_bit = NP_TX_RESET[NP_TOGGLE];
        s.np_code = NP_TX_RESET[10:0];
        return s;
    endfunction

    // ********************************************************
    // State
    // ********************************************************
    bank_state_t s_q;
    bank_state_t s_d;
    logic        wr_fire;
    logic        rd_fire;
    logic        load_ok;
    logic [15:0] merged;

    // Handshake outputs are combinational from the state flops
    always_comb begin
        rsp.awready = !s_q.aw_got && !s_q.bvalid;
        rsp.wready  = !s_q.w_got && !s_q.bvalid;
        rsp.bvalid  = s_q.bvalid;
        rsp.bresp   = s_q.bresp;
        rsp.arready = !s_q.rvalid;
        rsp.rvalid  = s_q.rvalid;
        rsp.rdata   = {16'h0000, s_q.rdata};
        rsp.rresp   = s_q.rresp;
    end

    assign next_page_word     = np_word(s_q);
    assign page_received_copy = s_q.page_rcvd;

    // ********************************************************
    // Next-state logic
    // ********************************************************
    always_comb begin
        s_d     = s_q;
        wr_fire = s_q.aw_got && s_q.w_got;
        rd_fire = req.arvalid && !s_q.rvalid;
        merged  = merge16(np_word(s_q), s_q.wdata, s_q.wstrb);
        // later pages only once next pages are in use
        load_ok = !neg_in.base_done ||
                  (LOCAL_NP_CAPABLE && neg_in.partner_multi_page_capable);

        // Write address and data are taken in either order
        if (req.awvalid && rsp.awready) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = req.awaddr;
        end
        if (req.wvalid && rsp.wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = req.wdata[15:0];
            s_d.wstrb = req.wstrb[1:0];
        end
        if (s_q.bvalid && req.bready) begin
            s_d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = mapped(s_q.aw_addr) ? RESP_OKAY : RESP_DECERR;
            // only the next-page word takes writes
            if (addr_hit(s_q.aw_addr, OFS_NP_TX)) begin
                s_d.next_page_request = merged[NP_SEND];
                s_d.message_page_select = merged[NP_MSG_PAGE];
                s_d.will_comply_flag = merged[NP_COMPLY];
                s_d.np_code = merged[10:0];
            end
        end

        if (s_q.rvalid && req.rready) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = read_word(req.araddr, s_q);
            s_d.rresp  = mapped(req.araddr) ? RESP_OKAY : RESP_DECERR;
            if (addr_hit(req.araddr, OFS_EXPANSION)) begin
                s_d.page_rcvd = 1'b0;
            end
        end

        // ****************************************************
        // Updates from the negotiation logic
        // ****************************************************
        if (neg_in.page_rx && load_ok) begin
            s_d.ability = neg_in.page_word & ~PA_RSVD_MASK;
        end
        s_d.ability[PA_RSVD_HI:PA_RSVD_LO] = 3'h0;
        s_d.ability[PA_ACK] = neg_in.partner_ack;
        // set wins over the read clear
        if (neg_in.page_rx) begin
            s_d.page_rcvd = 1'b1;
        end
        s_d.pd_fault = neg_in.parallel_detect_fault;
        s_d.lp_multi_page = neg_in.partner_multi_page_capable;
        s_d.lp_neg_capable = neg_in.partner_negotiation_capable;
        // next page carries the opposite toggle
        if (neg_in.np_page_sent) begin
            s_d.alternating_sync_bit = !s_q.alternating_sync_bit;
        end
    end

    // Reset overrides the clock enable so defaults load even when frozen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= reset_state();
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    sequence wr_np_full_s;
        ce && wr_fire && addr_hit(s_q.aw_addr, OFS_NP_TX) && s_q.wstrb == 2'h3;
    endsequence

    sequence rd_exp_s;
        ce && req.arvalid && rsp.arready && addr_hit(req.araddr, OFS_EXPANSION);
    endsequence

    sequence wr_ro_s;
        ce && wr_fire && !neg_in.page_rx &&
        (addr_hit(s_q.aw_addr, OFS_PARTNER) || addr_hit(s_q.aw_addr, OFS_EXPANSION));
    endsequence

    sequence rd_np_s;
        ce && req.arvalid && rsp.arready && addr_hit(req.araddr, OFS_NP_TX);
    endsequence

    sequence page_load_s;
        ce && neg_in.page_rx && load_ok;
    endsequence

    sequence page_skip_s;
        ce && neg_in.page_rx && !load_ok;
    endsequence

    reset_defaults_a: assert property (@(posedge aclk)
        !aresetn |=> s_q.ability == PARTNER_RESET &&
                     exp_word(s_q) == EXPANSION_RESET &&
                     np_word(s_q) == NP_TX_RESET)
        else $error("register defaults wrong after reset");

    ability_rsvd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_q.ability & PA_RSVD_MASK) == 16'h0000)
        else $error("reserved ability bits not zero");

    ack_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> s_q.ability[PA_ACK] == $past(neg_in.partner_ack))
        else $error("ability acknowledge bit does not follow");

    page_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && neg_in.page_rx && load_ok |=>
            s_q.ability[15] == $past(neg_in.page_word[15]) &&
            s_q.ability[9:0] == $past(neg_in.page_word[9:0]))
        else $error("received page not captured");

    page_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && neg_in.page_rx |=> s_q.page_rcvd && page_received_copy)
        else $error("page received flag not set");

    page_cor_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_exp_s and (!neg_in.page_rx) |=> !s_q.page_rcvd)
        else $error("expansion read did not clear page flag");

    copy_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && s_q.page_rcvd && !(req.arvalid && rsp.arready &&
            addr_hit(req.araddr, OFS_EXPANSION)) |=> page_received_copy)
        else $error("page flag copy lost without expansion read");

    np_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_np_full_s |=> (next_page_word & NP_WR_MASK) ==
                         ($past(s_q.wdata) & NP_WR_MASK))
        else $error("next-page write not stored");

    ro_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ro_s |=> s_q.ability[15:0] == {$past(s_q.ability[15]),
            s_q.ability[14], $past(s_q.ability[13:0])} || $past(!ce))
        else $error("write changed a read-only field");

    toggle_flip_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && neg_in.np_page_sent |=>
            s_q.alternating_sync_bit != $past(s_q.alternating_sync_bit))
        else $error("toggle bit did not invert");

    rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && req.arvalid && rsp.arready |=> rsp.rvalid)
        else $error("read not answered next cycle");

    resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rsp.bvalid && !req.bready |=> rsp.bvalid && $stable(rsp.bresp))
        else $error("write response dropped before bready");

    // ********************************************************
    // Field checks
    // ********************************************************
    // Partner word moves only on a loaded page, bit 14 aside
    hold_ability_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !neg_in.page_rx |=> s_q.ability[15] == $past(s_q.ability[15]) &&
            s_q.ability[13:0] == $past(s_q.ability[13:0]))
        else $error("ability word changed without a page");

    fault_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        page_load_s |=> s_q.ability[13] == $past(neg_in.page_word[13]))
        else $error("remote fault bit not captured");

    skip_page_a: assert property (@(posedge aclk) disable iff (!aresetn)
        page_skip_s |=> s_q.ability[15] == $past(s_q.ability[15]) &&
            s_q.ability[13:0] == $past(s_q.ability[13:0]))
        else $error("page loaded while next pages are off");

    pd_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> s_q.pd_fault == $past(neg_in.parallel_detect_fault))
        else $error("parallel detect fault bit does not follow");

    lp_pages_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> s_q.lp_multi_page == $past(neg_in.partner_multi_page_capable))
        else $error("partner page ability bit does not follow");

    lp_neg_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> s_q.lp_neg_capable == $past(neg_in.partner_negotiation_capable))
        else $error("partner negotiation bit does not follow");

    exp_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_exp_s |=> rsp.rdata[31:5] == '0 && rsp.rdata[EXP_LOCAL_NP] == LOCAL_NP_CAPABLE)
        else $error("expansion read shows wrong fixed bits");

    cor_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_exp_s |=> rsp.rdata[1] == $past(s_q.page_rcvd))
        else $error("expansion read lost the page flag");

    np_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_np_s |=> rsp.rdata[15:0] == $past(next_page_word))
        else $error("next-page read differs from sent word");

    // Software cannot move the toggle; only a sent page does
    toggle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && !neg_in.np_page_sent |=>
            s_q.alternating_sync_bit == $past(s_q.alternating_sync_bit))
        else $error("toggle bit moved without a sent page");

    wr_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && wr_fire |=> rsp.bvalid)
        else $error("write not answered after commit");

    freeze_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ce |=> $stable(s_q))
        else $error("state moved while clock enable low");

endmodule // autoneg_partner_nextpage_regs

// ===== an_regs_pkg.sv
// Package for the negotiation result and next-page register bank.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package an_regs_pkg;

    // ********************************************************
    // Register map, byte addresses
    // ********************************************************
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_PARTNER     = 8'h94;
    localparam logic [7:0]  OFS_EXPANSION   = 8'h98;
    localparam logic [7:0]  OFS_NP_TX       = 8'h9C;
    localparam logic [7:0]  OFS_XCVR_STATUS = 8'hC0;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [15:0] PARTNER_RESET   = 16'h0000;
    localparam logic [15:0] EXPANSION_RESET = 16'h0004;
    localparam logic [15:0] NP_TX_RESET     = 16'h2001;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int          PA_NEXT_PAGE    = 15;
    localparam int          PA_ACK          = 14;
    localparam int          PA_RSVD_HI      = 12;
    localparam int          PA_RSVD_LO      = 10;
    localparam int          EXP_LOCAL_NP    = 2;
    localparam int          NP_SEND         = 15;
    localparam int          NP_MSG_PAGE     = 13;
    localparam int          NP_COMPLY       = 12;
    localparam int          NP_TOGGLE       = 11;
    localparam int          STS_PAGE_COPY   = 8;
    localparam logic [15:0] NP_WR_MASK      = 16'hB7FF;
    localparam logic [15:0] PA_RSVD_MASK    = 16'h1C00;

    // ********************************************************
    // Bus responses
    // ********************************************************
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_DECERR     = 2'h3;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic        page_rx;
        logic [15:0] page_word;
        logic        base_done;
        logic        partner_ack;
        logic        partner_multi_page_capable;
        logic        partner_negotiation_capable;
        logic        parallel_detect_fault;
        logic        np_page_sent;
    } neg_in_t;

    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [15:0] wdata;
        logic [1:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [15:0] rdata;
        logic [1:0]  rresp;
        logic [15:0] ability;
        logic        pd_fault;
        logic        lp_multi_page;
        logic        page_rcvd;
        logic        lp_neg_capable;
        logic        next_page_request;
        logic        message_page_select;
        logic        will_comply_flag;
        logic        alternating_sync_bit;
        logic [10:0] np_code;
    } bank_state_t;

endpackage

// ===== neg_partner_model.sv
// Behavioural model of the negotiation arbitration side of the register bank.
// Assumes the bench calls its tasks from one process, right after a rising edge.
`timescale 1ns/1ns
module neg_partner_model
    import an_regs_pkg::*;
(
    input  wire logic    aclk,
    output      neg_in_t neg_in
);
    logic        rx_q   = 1'b0;
    logic        sent_q = 1'b0;
    logic [15:0] word_q = 16'h0000;
    logic [15:0] scr_q  = 16'h5A5A;
    logic [4:0]  lv_q   = 5'h00;

    // Word lines are only meaningful with the strobe, so they churn otherwise
    always @(posedge aclk) begin
        scr_q <= {scr_q[14:0], ~scr_q[15]};
    end

    always_comb begin
        neg_in.page_rx                     = rx_q;
        neg_in.page_word                   = rx_q ? word_q : scr_q;
        neg_in.base_done                   = lv_q[4];
        neg_in.partner_ack                 = lv_q[3];
        neg_in.partner_multi_page_capable  = lv_q[2];
        neg_in.partner_negotiation_capable = lv_q[1];
        neg_in.parallel_detect_fault       = lv_q[0];
        neg_in.np_page_sent                = sent_q;
    end

    task automatic set_levels(input logic [4:0] lv);
        @(posedge aclk);
        lv_q <= lv;
    endtask

    task automatic send_page(input logic [15:0] w);
        @(posedge aclk);
        rx_q   <= 1'b1;
        word_q <= w;
        @(posedge aclk);
        rx_q   <= 1'b0;
    endtask

    task automatic page_sent();
        @(posedge aclk);
        sent_q <= 1'b1;
        @(posedge aclk);
        sent_q <= 1'b0;
    endtask
endmodule // neg_partner_model

// ===== autoneg_partner_nextpage_regs_tb.sv
// Self-checking bench for the negotiation result and next-page register bank.
// Assumes the bank answers AXI4-Lite handshakes and the partner model feeds neg_in.
`timescale 1ns/1ns
module autoneg_partner_nextpage_regs_tb
    import an_regs_pkg::*;
;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic        ce      = 1'b1;
    axil_req_t   req     = '0;
    axil_rsp_t   rsp;
    neg_in_t     neg_in;
    logic [15:0] np_word;
    logic        pg_copy;
    int          n_fail  = 0;
    int          checks  = 0;

    always #50 aclk = ~aclk;

    autoneg_partner_nextpage_regs i_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .req(req), .rsp(rsp),
        .neg_in(neg_in), .next_page_word(np_word), .page_received_copy(pg_copy));

    neg_partner_model i_partner (.aclk(aclk), .neg_in(neg_in));

    // ********************************************************
    // Shared tasks
    // ********************************************************
    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        n_fail++;
        $display("[ERR] %0t no answer to %s", $time, what);
        results();
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s,
                          input logic [1:0] er);
        int n;
        @(posedge aclk);
        req.awaddr  <= a;
        req.awvalid <= 1'b1;
        // Upper lanes carry junk that the bank must ignore
        req.wdata   <= {~d, d};
        req.wstrb   <= {s, s};
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) break;
        end
        req.bready <= 1'b0;
        if (n == 40) hang("write");
        else chk(32'(rsp.bresp), 32'(er), $sformatf("bresp %h", a));
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready === 1'b1) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) break;
        end
        req.rready <= 1'b0;
        if (n == 40) hang("read");
        else begin
            chk(rsp.rdata, {16'h0000, e}, $sformatf("rdata %h", a));
            chk(32'(rsp.rresp), 32'(er), $sformatf("rresp %h", a));
        end
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic reset_values();
        rd_chk(OFS_PARTNER, 16'h0000, RESP_OKAY);
        rd_chk(OFS_EXPANSION, 16'h0004, RESP_OKAY);
        rd_chk(OFS_NP_TX, 16'h2001, RESP_OKAY);
        rd_chk(OFS_XCVR_STATUS, 16'h0000, RESP_OKAY);
        chk(32'(np_word), 32'h0000_2001, "np word port");
        chk(32'(pg_copy), 32'h0000_0000, "copy port");
    endtask

    // Levels are {base_done, ack, partner multi-page, partner negotiates, fault}
    task automatic page_capture();
        i_partner.set_levels(5'b01111);
        i_partner.send_page(16'hFFFF);
        rd_chk(OFS_PARTNER, 16'hE3FF, RESP_OKAY);
        chk(32'(pg_copy), 32'h0000_0001, "copy port set");
        rd_chk(OFS_XCVR_STATUS, 16'h0100, RESP_OKAY);
        rd_chk(OFS_XCVR_STATUS, 16'h0100, RESP_OKAY);
        rd_chk(OFS_EXPANSION, 16'h001F, RESP_OKAY);
        rd_chk(OFS_EXPANSION, 16'h001D, RESP_OKAY);
        chk(32'(pg_copy), 32'h0000_0000, "copy port clear");
        i_partner.set_levels(5'b00000);
        i_partner.send_page(16'h4015);
        rd_chk(OFS_PARTNER, 16'h0015, RESP_OKAY);
        rd_chk(OFS_EXPANSION, 16'h0006, RESP_OKAY);
    endtask

    // Later pages replace the word only when both sides take next pages
    task automatic page_replace();
        i_partner.set_levels(5'b10010);
        i_partner.send_page(16'h8123);
        rd_chk(OFS_PARTNER, 16'h0015, RESP_OKAY);
        i_partner.set_levels(5'b10110);
        i_partner.send_page(16'h8123);
        rd_chk(OFS_PARTNER, 16'h8123, RESP_OKAY);
    endtask

    task automatic write_effects();
        bus_wr(OFS_PARTNER, 16'hE3FF, 2'b11, RESP_OKAY);
        rd_chk(OFS_PARTNER, 16'h8123, RESP_OKAY);
        bus_wr(OFS_EXPANSION, 16'hFFFF, 2'b11, RESP_OKAY);
        rd_chk(OFS_EXPANSION, 16'h000F, RESP_OKAY);
        bus_wr(OFS_NP_TX, 16'hFFFF, 2'b11, RESP_OKAY);
        rd_chk(OFS_NP_TX, 16'hB7FF, RESP_OKAY);
        chk(32'(np_word), 32'h0000_B7FF, "np word port");
        bus_wr(OFS_NP_TX, 16'h0000, 2'b01, RESP_OKAY);
        rd_chk(OFS_NP_TX, 16'hB700, RESP_OKAY);
        i_partner.page_sent();
        rd_chk(OFS_NP_TX, 16'hBF00, RESP_OKAY);
        i_partner.page_sent();
        rd_chk(OFS_NP_TX, 16'hB700, RESP_OKAY);
        bus_wr(OFS_NP_TX, 16'h0800, 2'b11, RESP_OKAY);
        rd_chk(OFS_NP_TX, 16'h0000, RESP_OKAY);
        bus_wr(8'h40, 16'h1234, 2'b11, RESP_DECERR);
        rd_chk(8'h40, 16'h0000, RESP_DECERR);
    endtask

    // A page and a sent pulse while frozen must leave every field as it was
    task automatic ce_freeze();
        @(posedge aclk);
        ce <= 1'b0;
        i_partner.send_page(16'h0001);
        i_partner.page_sent();
        @(posedge aclk);
        ce <= 1'b1;
        rd_chk(OFS_PARTNER, 16'h8123, RESP_OKAY);
        rd_chk(OFS_EXPANSION, 16'h000D, RESP_OKAY);
        rd_chk(OFS_NP_TX, 16'h0000, RESP_OKAY);
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        reset_values();
        page_capture();
        page_replace();
        write_effects();
        ce_freeze();
        // Live levels would otherwise show through the reset values
        i_partner.set_levels(5'b00000);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        reset_values();
        results();
    end
endmodule // autoneg_partner_nextpage_regs_tb
